// ### bench/flash_prot_chk.sv
`timescale 1ns/100ps
module flash_prot_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register bus
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // flash macro and pins
   input wire logic flashReq,
   input wire flash_prot_pkg::flash_cmd_type flashCmd,
   input wire logic flashDone,
   input wire logic appPinsLost,
   input wire logic debugSerialDataOe,
   input wire logic debugSerialClockOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire [5:0] regIdx = address[7:2];
   wire [1:0] progSect = (flashCmd.addr >= flash_prot_pkg::SECT0_BASE) ? flash_prot_pkg::SECT0 :
      (flashCmd.addr >= flash_prot_pkg::SECT1_BASE) ? flash_prot_pkg::SECT1 : flash_prot_pkg::SECT2;
   chk_req_pulse: assert property (flashReq |=> !flashReq)
      else $error("flash request longer than one cycle");
   chk_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus request not answered after one wait cycle");
   chk_unmapped_zero: assert property (read && !waitrequest && (regIdx < 6'h29 || regIdx > 6'h2E)
      |-> readdata == 32'h00000000)
      else $error("unmapped read not zero");
   chk_reg_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("upper read data bits set");
   chk_pins_lost: assert property (appPinsLost |-> !debugSerialDataOe && !debugSerialClockOe)
      else $error("application drives debug pins after tool connect");
   chk_sw_sector0: assert property (flashReq && !appPinsLost |-> flashCmd.sector != flash_prot_pkg::SECT0
      && flashCmd.op inside {flash_prot_pkg::OP_PROG, flash_prot_pkg::OP_SECT_ERASE})
      else $error("software mode operation reached a protected target");
   chk_prog_sector: assert property (flashReq && flashCmd.op == flash_prot_pkg::OP_PROG
      |-> flashCmd.sector == progSect)
      else $error("program sector does not match address");
   chk_erase_sector: assert property (flashReq && flashCmd.op == flash_prot_pkg::OP_SECT_ERASE
      |-> flashCmd.sector != flash_prot_pkg::SECT_NONE)
      else $error("erase of absent sector");
   chk_req_cause: assert property (flashReq |-> $past(flashDone) || $past(write && !waitrequest
      && regIdx == flash_prot_pkg::IDX_CTRL))
      else $error("flash request without a control write");
endmodule

// ### bench/prog_tool_model.sv
`timescale 1ns/100ps
module prog_tool_model
(
   // tool controls
   input wire logic frameOn,
   input wire logic supplyOn,
   // debug port
   output logic debugSerialClock,
   output logic debugSerialDataIn,
   output logic progVoltageSelect
);
   // tool supplies its own clock, stands low between frames
   // data line floats between frames, so it toggles rather than holding a value
   initial
   begin
      debugSerialClock = 1'b0;
      debugSerialDataIn = 1'b0;
      #17.3;
      forever
      begin
         #62.5;
         debugSerialClock = frameOn ? ~debugSerialClock : 1'b0;
         debugSerialDataIn = ~debugSerialDataIn;
      end
   end
   assign progVoltageSelect = supplyOn;
endmodule

// ### bench/tb_flash_sector_protection_ctrl.sv
`timescale 1ns/100ps
module tb_flash_sector_protection_ctrl;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic flashReq;
   flash_prot_pkg::flash_cmd_type flashCmd;
   flash_prot_pkg::flash_cmd_type ops[$];
   logic flashDone = 1'b0;
   logic optionLoadValid = 1'b0;
   logic [7:0] optionLoadValue = 8'h00;
   logic debugSerialClock, debugSerialDataIn, progVoltageSelect;
   logic debugSerialDataOut, debugSerialDataOe, debugSerialClockOut, debugSerialClockOe;
   logic [3:0] app = 4'h0;
   logic [3:0] appPrev = 4'h0;
   logic appPinsLost, externalReadAllow;
   logic frameOn = 1'b0;
   logic supplyOn = 1'b1;
   logic [31:0] rd;
   int errTotal = 0;
   int totalChecks = 0;
   always #12.5 clk = ~clk;
   flash_sector_protection_ctrl i_flash_sector_protection_ctrl (.clk, .rst_b, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .flashReq, .flashCmd, .flashDone,
      .optionLoadValid, .optionLoadValue, .debugSerialClock, .debugSerialDataIn,
      .debugSerialDataOut, .debugSerialDataOe, .debugSerialClockOut, .debugSerialClockOe,
      .progVoltageSelect, .appDataOut(app[0]), .appDataOe(app[1]), .appClockOut(app[2]),
      .appClockOe(app[3]), .appPinsLost, .externalReadAllow);
   prog_tool_model i_prog_tool_model (.frameOn, .supplyOn, .debugSerialClock,
      .debugSerialDataIn, .progVoltageSelect);
   always @(posedge clk) if (rst_b) app <= 4'($urandom);
   // pins are registered, so they show the drive seen one edge earlier
   always @(posedge clk) appPrev <= app;
   wire [3:0] pinsOut = {debugSerialClockOe, debugSerialClockOut, debugSerialDataOe,
      debugSerialDataOut};
   // flash macro stand-in: random completion delay
   initial forever
   begin
      @(posedge clk);
      if (flashReq === 1'b1)
      begin
         ops.push_back(flashCmd);
         repeat ($urandom_range(1, 6)) @(posedge clk);
         flashDone <= 1'b1;
         @(posedge clk);
         flashDone <= 1'b0;
      end
   end
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", totalChecks, errTotal);
      if (errTotal == 0 && totalChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      totalChecks++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, msg, seen, exp);
      end
   endtask
   // master holds the request until it samples waitrequest low
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= ~wr;
      writedata <= {24'h000000, wd};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 40);
      chk({31'h0, n < 40}, 32'h1, "bus answer");
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   function automatic logic [1:0] expSect(input logic [15:0] a);
      return (a >= flash_prot_pkg::SECT0_BASE) ? flash_prot_pkg::SECT0 :
         (a >= flash_prot_pkg::SECT1_BASE) ? flash_prot_pkg::SECT1 : flash_prot_pkg::SECT2;
   endfunction
   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input string msg);
      bus(1'b0, idx, 8'h00);
      chk(rd, exp, msg);
   endtask
   // launch one command, wait for idle, compare what reached the flash macro
   task automatic run(input logic [7:0] cv, input int n, input flash_prot_pkg::flash_op_type eop,
      input logic [1:0] es);
      int k;
      ops.delete();
      bus(1'b1, flash_prot_pkg::IDX_CTRL, cv);
      k = 0;
      do
      begin
         bus(1'b0, flash_prot_pkg::IDX_CTRL, 8'h00);
         k++;
      end
      while (rd[7] !== 1'b0 && k < 30);
      chk({31'h0, rd[7]}, 32'h0, "busy cleared");
      chk(32'(ops.size()), 32'(n), "operation count");
      chk({31'h0, rd[6]}, {31'h0, n == 0}, "refusal flag");
      if (n > 0) chk(32'(ops[0].op), 32'(eop), "operation kind");
      if (n > 0 && eop != flash_prot_pkg::OP_MASS_ERASE && eop != flash_prot_pkg::OP_OPT_WRITE)
         chk({30'h0, ops[0].sector}, {30'h0, es}, "operation sector");
      bus(1'b1, flash_prot_pkg::IDX_CTRL, 8'h40);
   endtask
   task automatic prog(input logic [15:0] a, input int n);
      logic [7:0] wd;
      wd = 8'($urandom);
      bus(1'b1, flash_prot_pkg::IDX_ADDR_LO, a[7:0]);
      bus(1'b1, flash_prot_pkg::IDX_ADDR_HI, a[15:8]);
      bus(1'b1, flash_prot_pkg::IDX_WDATA, wd);
      run(8'h01, n, flash_prot_pkg::OP_PROG, expSect(a));
      if (n > 0) chk({16'h0, ops[0].addr}, {16'h0, a}, "program address");
      if (n > 0) chk({24'h0, ops[0].data}, {24'h0, wd}, "program data");
   endtask
   initial
   begin
      #1ms;
      errTotal++;
      $display("[ERR] %0t watchdog expired", $time);
      printVerdict();
   end
   initial
   begin
      logic [15:0] al[6];
      void'($urandom(33));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1; // only the tool-side reset is ever applied
      rdc(flash_prot_pkg::IDX_CTRL, 32'h0, "control reset");
      rdc(flash_prot_pkg::IDX_STATUS, 32'h4, "status idle");
      rdc(6'h10, 32'h0, "unmapped read");
      bus(1'b1, 6'h10, 8'hFF);
      bus(1'b1, flash_prot_pkg::IDX_CTRL, 8'h30);
      rdc(flash_prot_pkg::IDX_CTRL, 32'h30, "control read back");
      bus(1'b1, flash_prot_pkg::IDX_CTRL, 8'h00);
      repeat (4)
      begin
         @(posedge clk);
         chk({28'h0, pinsOut}, {28'h0, appPrev}, "application pins");
      end
      $display("test registers done");
      al = '{16'hF000, 16'hEFFF, 16'hE000, 16'hDFFF, 16'hE000, 16'h8000};
      al[4] = al[4] + 16'($urandom_range(0, 4095));
      al[5] = al[5] + 16'($urandom_range(0, 24575));
      foreach (al[i]) prog(al[i], expSect(al[i]) != flash_prot_pkg::SECT0);
      for (int s = 0; s < 4; s++)
         run({2'b00, 2'(s), 4'h2}, s == 1 || s == 2, flash_prot_pkg::OP_SECT_ERASE, 2'(s));
      run(8'h04, 0, flash_prot_pkg::OP_MASS_ERASE, 2'h0);
      run(8'h08, 0, flash_prot_pkg::OP_OPT_WRITE, 2'h0);
      supplyOn <= 1'b0;
      repeat (4) @(posedge clk);
      prog(16'hE010, 0);
      supplyOn <= 1'b1;
      $display("test software mode done");
      optionLoadValue <= 8'h01;
      optionLoadValid <= 1'b1;
      @(posedge clk);
      optionLoadValid <= 1'b0;
      rdc(flash_prot_pkg::IDX_STATUS, 32'h6, "protected status");
      rdc(flash_prot_pkg::IDX_OPTION, 32'h1, "option byte");
      chk({31'h0, externalReadAllow}, 32'h0, "readout blocked");
      prog(16'hE000, 0);
      frameOn <= 1'b1;
      repeat (100) @(posedge clk);
      frameOn <= 1'b0;
      repeat (10) @(posedge clk);
      chk({29'h0, appPinsLost, debugSerialDataOe, debugSerialClockOe}, 32'h4, "pins");
      @(posedge clk);
      chk({28'h0, pinsOut}, {28'h0, appPrev & 4'h5}, "tool mode pins");
      rdc(flash_prot_pkg::IDX_STATUS, 32'h7, "tool status");
      prog(16'hF000, 0);
      $display("test protection done");
      bus(1'b1, flash_prot_pkg::IDX_OPTION, 8'h00);
      run(8'h08, 2, flash_prot_pkg::OP_MASS_ERASE, 2'h0);
      chk(32'(ops[1].op), 32'(flash_prot_pkg::OP_OPT_WRITE), "option after erase");
      chk(32'(ops[1].data), 32'h0, "staged option value");
      rdc(flash_prot_pkg::IDX_STATUS, 32'h5, "unprotected status");
      chk({31'h0, externalReadAllow}, 32'h1, "readout allowed");
      run(8'h02, 1, flash_prot_pkg::OP_SECT_ERASE, flash_prot_pkg::SECT0);
      run(8'h04, 1, flash_prot_pkg::OP_MASS_ERASE, 2'h0);
      prog(16'hFFFE, 1);
      run(8'h08, 1, flash_prot_pkg::OP_OPT_WRITE, 2'h0);
      $display("test tool mode done");
      printVerdict();
   end
endmodule
bind flash_sector_protection_ctrl flash_prot_chk i_flash_prot_chk (.clk, .rst_b, .address,
   .read, .write, .readdata, .waitrequest, .flashReq, .flashCmd, .flashDone, .appPinsLost,
   .debugSerialDataOe, .debugSerialClockOe);

// ### common/flash_prot_pkg.sv
// Functional notes
// - flash erases whole or per sector, programs single bytes, other sectors untouched.
// - 4K array has sector 0; 8K adds sector 1; larger adds sector 2.
// - sectors 0 and 1 are 4K at top; sector 0 holds vectors.
// - software-driven programming may touch every sector except sector 0.
// - tool-driven programming may erase/program all sectors and the option byte.
// - readout protection blocks external readout and any flash array write.
// - removing readout protection first erases the whole program memory automatically.
// - readout protection comes from one option byte bit, not a run-time register.
// - 8-bit read/write control/status register, index 29h, reset 00h, for tool software.
// - once tool is connected, debug clock/data pins are lost to the application.
package flash_prot_pkg;

   // array size option
   localparam int unsigned FLASH_KBYTES = 32;
   localparam logic [1:0] SECT0 = 2'h0;
   localparam logic [1:0] SECT1 = 2'h1;
   localparam logic [1:0] SECT2 = 2'h2;
   localparam logic [1:0] SECT_NONE = 2'h3;
   localparam logic [15:0] SECT0_BASE = 16'hF000;
   localparam logic [15:0] SECT1_BASE = 16'hE000;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL = 6'h29;
   localparam logic [5:0] IDX_ADDR_LO = 6'h2A;
   localparam logic [5:0] IDX_ADDR_HI = 6'h2B;
   localparam logic [5:0] IDX_WDATA = 6'h2C;
   localparam logic [5:0] IDX_OPTION = 6'h2D;
   localparam logic [5:0] IDX_STATUS = 6'h2E;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'h00;

   // control/status and option fields
   localparam int unsigned CTRL_PROG = 0;
   localparam int unsigned CTRL_SECT_ERASE = 1;
   localparam int unsigned CTRL_MASS_ERASE = 2;
   localparam int unsigned CTRL_OPT_WRITE = 3;
   localparam int unsigned CTRL_SEL_LO = 4;
   localparam int unsigned CTRL_REFUSED = 6;
   localparam int unsigned CTRL_BUSY = 7;
   localparam int unsigned OPT_PROTECT = 0;

   // status fields
   localparam int unsigned STAT_TOOL = 0;
   localparam int unsigned STAT_PROTECT = 1;
   localparam int unsigned STAT_VPP = 2;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_PROG,
      OP_SECT_ERASE,
      OP_MASS_ERASE,
      OP_OPT_WRITE
   } flash_op_type;

   typedef struct packed {
      flash_op_type op;
      logic [1:0] sector;
      logic [15:0] addr;
      logic [7:0] data;
   } flash_cmd_type;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avs_req_type;

endpackage

// ### hdl/flash_sector_protection_ctrl.sv
`timescale 1ns/100ps
module flash_sector_protection_ctrl
(
   // system clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // flash macro
   output logic flashReq,
   output flash_prot_pkg::flash_cmd_type flashCmd,
   input wire logic flashDone,
   input wire logic optionLoadValid,
   input wire logic [7:0] optionLoadValue,
   // debug port pins
   input wire logic debugSerialClock,
   input wire logic debugSerialDataIn,
   output logic debugSerialDataOut,
   output logic debugSerialDataOe,
   output logic debugSerialClockOut,
   output logic debugSerialClockOe,
   input wire logic progVoltageSelect,
   // application side of the shared pins
   input wire logic appDataOut,
   input wire logic appDataOe,
   input wire logic appClockOut,
   input wire logic appClockOe,
   output logic appPinsLost,
   output logic externalReadAllow
);

   typedef enum {
      ST_IDLE,
      ST_RUN,
      ST_UNPROT_ERASE,
      ST_UNPROT_OPT
   } state_type;

   // sector of a byte address
   function automatic logic [1:0] sectorOf(input logic [15:0] addr);
      if (addr >= flash_prot_pkg::SECT0_BASE)
         sectorOf = flash_prot_pkg::SECT0;
      else if (addr >= flash_prot_pkg::SECT1_BASE)
         sectorOf = flash_prot_pkg::SECT1;
      else
         sectorOf = flash_prot_pkg::SECT2;
   endfunction

   // highest sector present for an array size
   function automatic logic [1:0] topSector(input int unsigned kbytes);
      if (kbytes <= 4)
         topSector = flash_prot_pkg::SECT0;
      else if (kbytes <= 8)
         topSector = flash_prot_pkg::SECT1;
      else
         topSector = flash_prot_pkg::SECT2;
   endfunction

   localparam logic [1:0] TOP_SECTOR = topSector(flash_prot_pkg::FLASH_KBYTES);

   // link domain: tool presence, cleared only by device reset driven by the tool
   logic linkSeen_r;
   always_ff @(posedge debugSerialClock or negedge rst_b)
   begin
      if (!rst_b)
         linkSeen_r <= 1'b0;
      else
         linkSeen_r <= 1'b1;
   end

   // level crossing into the system domain
   logic toolSync1_r;
   logic toolSync2_r;
   logic vppSync1_r;
   logic vppSync2_r;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         toolSync1_r <= 1'b0;
         toolSync2_r <= 1'b0;
         vppSync1_r <= 1'b0;
         vppSync2_r <= 1'b0;
      end
      else
      begin
         toolSync1_r <= linkSeen_r;
         toolSync2_r <= toolSync1_r;
         vppSync1_r <= progVoltageSelect;
         vppSync2_r <= vppSync1_r;
      end
   end

   wire toolMode = toolSync2_r;
   wire vppOk = vppSync2_r;

   // bus decode
   flash_prot_pkg::avs_req_type req;
   assign req = '{address: address, read: read, write: write, writedata: writedata};

   logic waitrequest_r;
   logic [31:0] readdata_r;
   wire [5:0] regIdx = req.address[7:2];
   wire accessNow = (req.read || req.write) && waitrequest_r;
   wire wrAccept = req.write && !waitrequest_r;
   wire wrCtrl = wrAccept && (regIdx == flash_prot_pkg::IDX_CTRL);
   wire wrAddrLo = wrAccept && (regIdx == flash_prot_pkg::IDX_ADDR_LO);
   wire wrAddrHi = wrAccept && (regIdx == flash_prot_pkg::IDX_ADDR_HI);
   wire wrWdata = wrAccept && (regIdx == flash_prot_pkg::IDX_WDATA);
   wire wrOption = wrAccept && (regIdx == flash_prot_pkg::IDX_OPTION);

   // registers
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [15:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] optStage_r;
   logic [7:0] option_r;
   logic [7:0] option_nxt;
   state_type state_r;
   state_type state_nxt;
   logic flashReq_r;
   logic flashReq_nxt;
   flash_prot_pkg::flash_cmd_type flashCmd_r;
   flash_prot_pkg::flash_cmd_type flashCmd_nxt;

   wire isProtected = option_r[flash_prot_pkg::OPT_PROTECT];
   wire busy = (state_r != ST_IDLE);

   // command chosen from a control write; mass erase wins over the rest
   wire [7:0] wc = writedata[7:0];
   wire [1:0] selSector = wc[flash_prot_pkg::CTRL_SEL_LO +: 2];
   wire [1:0] progSector = sectorOf(addr_r);
   flash_prot_pkg::flash_op_type reqOp;
   assign reqOp = !wrCtrl ? flash_prot_pkg::OP_NONE :
                  wc[flash_prot_pkg::CTRL_MASS_ERASE] ? flash_prot_pkg::OP_MASS_ERASE :
                  wc[flash_prot_pkg::CTRL_SECT_ERASE] ? flash_prot_pkg::OP_SECT_ERASE :
                  wc[flash_prot_pkg::CTRL_PROG] ? flash_prot_pkg::OP_PROG :
                  wc[flash_prot_pkg::CTRL_OPT_WRITE] ? flash_prot_pkg::OP_OPT_WRITE :
                  flash_prot_pkg::OP_NONE;

   wire [1:0] reqSector = (reqOp == flash_prot_pkg::OP_SECT_ERASE) ? selSector :
                          (reqOp == flash_prot_pkg::OP_PROG) ? progSector :
                          flash_prot_pkg::SECT0;
   wire sectorPresent = (reqSector <= TOP_SECTOR);
   // software may never touch sector 0, hence never mass erase or option
   wire modeOk = toolMode ? 1'b1 :
                 ((reqOp == flash_prot_pkg::OP_PROG) ||
                  (reqOp == flash_prot_pkg::OP_SECT_ERASE)) &&
                 (reqSector != flash_prot_pkg::SECT0);
   // only the option write itself may pass while protected
   wire protOk = !isProtected || (reqOp == flash_prot_pkg::OP_OPT_WRITE);
   wire reqOk = sectorPresent && modeOk && protOk && vppOk && !busy;
   wire reqRefused = (reqOp != flash_prot_pkg::OP_NONE) && !reqOk;
   wire launch = (reqOp != flash_prot_pkg::OP_NONE) && reqOk;
   wire unprotect = isProtected && !optStage_r[flash_prot_pkg::OPT_PROTECT];

   always_comb
   begin
      state_nxt = state_r;
      flashReq_nxt = 1'b0;
      flashCmd_nxt = flashCmd_r;
      option_nxt = option_r;
      ctrl_nxt = ctrl_r;
      if (wrCtrl)
      begin
         ctrl_nxt[flash_prot_pkg::CTRL_SEL_LO +: 2] = selSector;
         // refused flag clears on writing one
         if (wc[flash_prot_pkg::CTRL_REFUSED])
            ctrl_nxt[flash_prot_pkg::CTRL_REFUSED] = 1'b0;
      end
      case (state_r)
         ST_IDLE:
         begin
            if (launch)
            begin
               ctrl_nxt[3:0] = wc[3:0];
               flashReq_nxt = 1'b1;
               flashCmd_nxt.sector = reqSector;
               flashCmd_nxt.addr = addr_r;
               flashCmd_nxt.data = (reqOp == flash_prot_pkg::OP_OPT_WRITE) ? optStage_r : wdata_r;
               if ((reqOp == flash_prot_pkg::OP_OPT_WRITE) && unprotect)
               begin
                  flashCmd_nxt.op = flash_prot_pkg::OP_MASS_ERASE;
                  state_nxt = ST_UNPROT_ERASE;
               end
               else
               begin
                  flashCmd_nxt.op = reqOp;
                  state_nxt = ST_RUN;
               end
            end
         end
         ST_UNPROT_ERASE:
         begin
            // protection stays on until the array is blank
            if (flashDone)
            begin
               flashReq_nxt = 1'b1;
               flashCmd_nxt.op = flash_prot_pkg::OP_OPT_WRITE;
               state_nxt = ST_UNPROT_OPT;
            end
         end
         ST_RUN, ST_UNPROT_OPT:
         begin
            if (flashDone)
            begin
               if (flashCmd_r.op == flash_prot_pkg::OP_OPT_WRITE)
                  option_nxt = flashCmd_r.data;
               ctrl_nxt[3:0] = 4'h0;
               state_nxt = ST_IDLE;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (optionLoadValid && !busy)
         option_nxt = optionLoadValue;
      // a refusal in the clearing cycle still sets the flag
      if (reqRefused)
         ctrl_nxt[flash_prot_pkg::CTRL_REFUSED] = 1'b1;
      ctrl_nxt[flash_prot_pkg::CTRL_BUSY] = (state_nxt != ST_IDLE);
   end

   // read mux; unmapped words read zero
   wire [7:0] statusWord = {5'h00, vppOk, isProtected, toolMode};
   wire [7:0] readByte = (regIdx == flash_prot_pkg::IDX_CTRL) ? ctrl_r :
                         (regIdx == flash_prot_pkg::IDX_ADDR_LO) ? addr_r[7:0] :
                         (regIdx == flash_prot_pkg::IDX_ADDR_HI) ? addr_r[15:8] :
                         (regIdx == flash_prot_pkg::IDX_WDATA) ? wdata_r :
                         (regIdx == flash_prot_pkg::IDX_OPTION) ? option_r :
                         (regIdx == flash_prot_pkg::IDX_STATUS) ? statusWord : 8'h00;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waitrequest_r <= 1'b1;
         readdata_r <= 32'h00000000;
      end
      else
      begin
         // one wait cycle, then a single low cycle per request
         waitrequest_r <= !accessNow;
         if (accessNow && req.read)
            readdata_r <= {24'h000000, readByte};
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_r <= flash_prot_pkg::CTRL_RESET;
         option_r <= flash_prot_pkg::OPTION_RESET;
         state_r <= ST_IDLE;
         flashReq_r <= 1'b0;
         flashCmd_r <= '{op: flash_prot_pkg::OP_NONE, sector: 2'h0, addr: 16'h0000, data: 8'h00};
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         option_r <= option_nxt;
         state_r <= state_nxt;
         flashReq_r <= flashReq_nxt;
         flashCmd_r <= flashCmd_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         optStage_r <= flash_prot_pkg::OPTION_RESET;
      end
      else
      begin
         if (wrAddrLo)
            addr_r[7:0] <= wc;
         if (wrAddrHi)
            addr_r[15:8] <= wc;
         if (wrWdata)
            wdata_r <= wc;
         if (wrOption)
            optStage_r <= wc;
      end
   end

   // shared pins: application loses them once the tool has shown up
   logic dataOut_r;
   logic dataOe_r;
   logic clkOut_r;
   logic clkOe_r;
   logic pinsLost_r;
   logic readAllow_r;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dataOut_r <= 1'b0;
         dataOe_r <= 1'b0;
         clkOut_r <= 1'b0;
         clkOe_r <= 1'b0;
         pinsLost_r <= 1'b0;
         readAllow_r <= 1'b0;
      end
      else
      begin
         dataOut_r <= appDataOut;
         dataOe_r <= appDataOe && !toolMode;
         clkOut_r <= appClockOut;
         clkOe_r <= appClockOe && !toolMode;
         pinsLost_r <= toolMode;
         // extraction by the tool is only allowed while unprotected
         readAllow_r <= !isProtected && (state_r == ST_IDLE);
      end
   end

   // debug data pin is not used by any logic in this block
   wire unusedDataIn = debugSerialDataIn;

   assign readdata = readdata_r;
   assign waitrequest = waitrequest_r;
   assign flashReq = flashReq_r;
   assign flashCmd = flashCmd_r;
   assign debugSerialDataOut = dataOut_r;
   assign debugSerialDataOe = dataOe_r;
   assign debugSerialClockOut = clkOut_r;
   assign debugSerialClockOe = clkOe_r;
   assign appPinsLost = pinsLost_r;
   assign externalReadAllow = readAllow_r;

endmodule
